// ### pkg/cltd_pkg.sv
/*
 * Shared constants and types of the control, literal and table decoder:
 * register offsets, status field positions, opcode fields and cycle counts.
 * Assumes a 32-bit AHB-Lite register bus and one 20 MHz clock.
 */
package cltd_pkg;

	// Register byte offsets.
	localparam logic [7:0] ADDR_INSTR = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_WORK = 8'h08;
	localparam logic [7:0] ADDR_PC = 8'h0C;
	localparam logic [7:0] ADDR_STKTOP = 8'h10;
	localparam logic [7:0] ADDR_BANK = 8'h14;
	localparam logic [7:0] ADDR_FSR0 = 8'h18;
	localparam logic [7:0] ADDR_FSR2 = 8'h20;
	localparam logic [7:0] ADDR_TBLPTR = 8'h24;
	localparam logic [7:0] ADDR_TABLAT = 8'h28;
	localparam logic [7:0] ADDR_PROD = 8'h2C;
	localparam logic [7:0] ADDR_PORT = 8'h30;
	localparam logic [7:0] ADDR_TIMER = 8'h34;
	localparam logic [7:0] ADDR_CTRL = 8'h38;

	// Control register fields.
	localparam int CTRL_TBLWR_EN = 0;
	localparam int CTRL_PSC_ASSIGN = 1;
	localparam int CTRL_PSC_SEL = 2;
	localparam logic [4:0] CTRL_RESET = 5'h00;

	// Status register fields above the five flag bits.
	localparam int STAT_TO = 5;
	localparam int STAT_PDN = 6;
	localparam int STAT_IRQH = 7;
	localparam int STAT_IRQL = 8;
	localparam int STAT_BUSY = 9;
	localparam int STAT_PEND = 10;
	localparam int STAT_STANDBY = 11;
	localparam int STAT_CYC = 12;
	localparam int STAT_SP = 16;

	// Opcode fields.
	localparam logic [3:0] OP_CTRL = 4'hE;
	localparam logic [3:0] OP_SECOND = 4'hF;
	localparam logic [3:0] OP_LIT = 4'h0;
	localparam logic [3:0] SUB_JUMP = 4'hF;
	localparam logic [3:0] SUB_PTRLD = 4'hE;
	localparam logic [3:0] LIT_ADD = 4'hF;
	localparam logic [3:0] LIT_AND = 4'hB;
	localparam logic [3:0] LIT_OR = 4'h9;
	localparam logic [3:0] LIT_XOR = 4'hA;
	localparam logic [3:0] LIT_MOVE = 4'hE;
	localparam logic [3:0] LIT_MUL = 4'hD;
	localparam logic [3:0] LIT_RET = 4'hC;
	localparam logic [3:0] LIT_SUB = 4'h8;
	localparam logic [3:0] LIT_BANK = 4'h1;
	localparam logic [7:0] MISC_PUSH = 8'h05;
	localparam logic [7:0] MISC_POP = 8'h06;
	localparam logic [6:0] MISC_IRET = 7'h08;
	localparam logic [7:0] MISC_STANDBY = 8'h03;
	localparam logic [5:0] MISC_TABLE = 6'h02;

	// Branch condition codes.
	localparam logic [3:0] CC_Z = 4'h0;
	localparam logic [3:0] CC_NZ = 4'h1;
	localparam logic [3:0] CC_C = 4'h2;
	localparam logic [3:0] CC_NC = 4'h3;
	localparam logic [3:0] CC_OV = 4'h4;
	localparam logic [3:0] CC_NOV = 4'h5;
	localparam logic [3:0] CC_N = 4'h6;
	localparam logic [3:0] CC_NN = 4'h7;

	// Table pointer update modes.
	localparam logic [1:0] TP_NONE = 2'b00;
	localparam logic [1:0] TP_POSTINC = 2'b01;
	localparam logic [1:0] TP_POSTDEC = 2'b10;
	localparam logic [1:0] TP_PREINC = 2'b11;

	// Cycle counts.
	localparam logic [3:0] CYC_ONE = 4'd1;
	localparam logic [3:0] CYC_TWO = 4'd2;
	localparam logic [3:0] CYC_TBLWR = 4'd5;

	localparam int PC_W = 21;
	localparam int TBL_DEPTH = 16;
	localparam int TBL_AW = 4;

	typedef struct packed {
		logic n;
		logic ov;
		logic z;
		logic dc;
		logic c;
	} cltd_flags_t;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
	} cltd_aphase_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXTRA = 2'b01,
		ST_TABLE_READ = 2'b10
	} cltd_state_t;

endpackage : cltd_pkg

// ### verilog/cltd_table_mem.sv
/*
 * Small table memory reached by table reads and writes.
 * Assumes one clock; read data appear one edge after the address.
 */
`timescale 1ns/100ps
`default_nettype none
module cltd_table_mem
(
	input wire logic hclk,
	input wire logic we,
	input wire logic [cltd_pkg::TBL_AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	import cltd_pkg::*;

	logic [7:0] mem_r [TBL_DEPTH];

	always_ff @(posedge hclk)
	begin
		if (we)
		begin
			mem_r[addr] <= wdata;
		end
		rdata <= mem_r[addr];
	end

endmodule : cltd_table_mem
`default_nettype wire

// ### verilog/cltd_decoder.sv
/*
 * Control, literal and table instruction decoder with its working state,
 * reached over an AHB-Lite slave port. Writing the instruction register
 * issues one 16-bit word while idle. Assumes a single master and zero-wait answers.
 */
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module cltd_decoder
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic [7:0] port_pins,
	output logic [7:0] port_latch,
	output logic standby
);
	import cltd_pkg::*;

	cltd_aphase_t aph_r;
	logic dph_r;
	logic [31:0] rd_mux;
	logic wr_go;
	logic [7:0] wr_addr;

	cltd_state_t state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [3:0] cyc_r, cyc_nxt;
	cltd_flags_t flg_r, flg_nxt;
	logic [7:0] w_r, w_nxt;
	logic [PC_W-1:0] pc_r, pc_nxt;
	logic [PC_W-1:0] top_r, top_nxt;
	logic [4:0] sp_r, sp_nxt;
	logic [3:0] bank_r, bank_nxt;
	logic [11:0] fsr_r [3];
	logic [11:0] fsr_val;
	logic [1:0] fsr_sel;
	logic fsr_we;
	logic [15:0] tptr_r, tptr_nxt;
	logic [7:0] tlat_r, tlat_nxt;
	logic [15:0] prod_r, prod_nxt;
	logic to_r, to_nxt, pdn_r, pdn_nxt;
	logic irqh_r, irqh_nxt, irql_r, irql_nxt;
	logic stby_r, stby_nxt;
	logic pend_r, pend_nxt;
	logic [15:0] first_r, first_nxt;
	logic [4:0] ctrl_r;
	logic [7:0] tmr_r;
	logic [7:0] psc_r;
	logic [7:0] psc_mask;
	logic tmr_tick;
	logic [7:0] latch_r;
	logic mem_we;
	logic [7:0] mem_rdata;
	logic [TBL_AW-1:0] mem_addr;

	logic issue;
	logic [15:0] iw;
	logic [7:0] k;
	logic [PC_W-1:0] pc_inc;
	logic cond_true;
	logic [8:0] add_sum, sub_sum;
	logic [4:0] add_lo, sub_lo;
	logic [7:0] logic_res;
	logic [15:0] tp_use;

	// Bus address phase capture and data phase decode.
	wire aph_valid = hsel && htrans[1] && hready;
	assign wr_go = dph_r && aph_r.wr;
	assign wr_addr = aph_r.addr;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = dph_r && !aph_r.wr ? rd_mux : 32'h0000_0000;
	assign port_latch = latch_r;
	assign standby = stby_r;

	wire sel_instr = wr_go && wr_addr == ADDR_INSTR;
	wire sel_work = wr_go && wr_addr == ADDR_WORK;
	wire sel_pc = wr_go && wr_addr == ADDR_PC;
	wire sel_top = wr_go && wr_addr == ADDR_STKTOP;
	wire sel_bank = wr_go && wr_addr == ADDR_BANK;
	wire sel_tptr = wr_go && wr_addr == ADDR_TBLPTR;
	wire sel_tlat = wr_go && wr_addr == ADDR_TABLAT;
	wire sel_port = wr_go && wr_addr == ADDR_PORT;
	wire sel_tmr = wr_go && wr_addr == ADDR_TIMER;
	wire sel_ctrl = wr_go && wr_addr == ADDR_CTRL;
	wire fsr_bus = wr_go && wr_addr >= ADDR_FSR0 && wr_addr <= ADDR_FSR2;
	wire [1:0] fsr_bus_idx = 2'(((wr_addr - ADDR_FSR0) >> 2));
	wire [1:0] fsr_rd_idx = 2'(((aph_r.addr - ADDR_FSR0) >> 2));

	// A word written while an instruction still runs is dropped.
	assign issue = sel_instr && state_r == ST_IDLE;
	assign iw = hwdata[15:0];
	assign k = iw[7:0];
	assign pc_inc = pc_r + PC_W'(2);

	always_comb
	begin
		case (aph_r.addr)
			ADDR_INSTR: rd_mux = {16'h0000, first_r};
			ADDR_STATUS: rd_mux = {11'h000, sp_r, cyc_r, stby_r, pend_r, state_r != ST_IDLE,
				irql_r, irqh_r, pdn_r, to_r, flg_r};
			ADDR_WORK: rd_mux = {24'h000000, w_r};
			ADDR_PC: rd_mux = {11'h000, pc_r};
			ADDR_STKTOP: rd_mux = {11'h000, top_r};
			ADDR_BANK: rd_mux = {28'h0000000, bank_r};
			ADDR_TBLPTR: rd_mux = {16'h0000, tptr_r};
			ADDR_TABLAT: rd_mux = {24'h000000, tlat_r};
			ADDR_PROD: rd_mux = {16'h0000, prod_r};
			ADDR_PORT: rd_mux = {24'h000000, port_pins};
			ADDR_TIMER: rd_mux = {24'h000000, tmr_r};
			ADDR_CTRL: rd_mux = {27'h0000000, ctrl_r};
			default: rd_mux = 32'h0000_0000;
		endcase
		if (aph_r.addr >= ADDR_FSR0 && aph_r.addr <= ADDR_FSR2)
		begin
			rd_mux = {20'h00000, fsr_r[fsr_rd_idx]};
		end
	end

	// Branch condition select.
	always_comb
	begin
		case (iw[11:8])
			CC_Z: cond_true = flg_r.z;
			CC_NZ: cond_true = !flg_r.z;
			CC_C: cond_true = flg_r.c;
			CC_NC: cond_true = !flg_r.c;
			CC_OV: cond_true = flg_r.ov;
			CC_NOV: cond_true = !flg_r.ov;
			CC_N: cond_true = flg_r.n;
			CC_NN: cond_true = !flg_r.n;
			default: cond_true = 1'b0;
		endcase
	end

	// Arithmetic for the literal group; subtraction is literal plus inverted W plus one.
	assign add_sum = {1'b0, w_r} + {1'b0, k};
	assign add_lo = {1'b0, w_r[3:0]} + {1'b0, k[3:0]};
	assign sub_sum = {1'b0, k} + {1'b0, ~w_r} + 9'h001;
	assign sub_lo = {1'b0, k[3:0]} + {1'b0, ~w_r[3:0]} + 5'h01;
	assign logic_res = iw[11:8] == LIT_AND ? (w_r & k) :
		iw[11:8] == LIT_OR ? (w_r | k) : (w_r ^ k);
	assign tp_use = iw[1:0] == TP_PREINC ? tptr_r + 16'h0001 : tptr_r;
	assign mem_addr = tp_use[TBL_AW-1:0];

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		cyc_nxt = cyc_r;
		flg_nxt = flg_r;
		w_nxt = sel_work ? hwdata[7:0] : w_r;
		pc_nxt = sel_pc ? hwdata[PC_W-1:0] : pc_r;
		top_nxt = sel_top ? hwdata[PC_W-1:0] : top_r;
		sp_nxt = sp_r;
		bank_nxt = sel_bank ? hwdata[3:0] : bank_r;
		tptr_nxt = sel_tptr ? hwdata[15:0] : tptr_r;
		tlat_nxt = sel_tlat ? hwdata[7:0] : tlat_r;
		prod_nxt = prod_r;
		to_nxt = to_r;
		pdn_nxt = pdn_r;
		irqh_nxt = irqh_r;
		irql_nxt = irql_r;
		stby_nxt = stby_r;
		pend_nxt = pend_r;
		first_nxt = first_r;
		fsr_we = fsr_bus;
		fsr_sel = fsr_bus_idx;
		fsr_val = hwdata[11:0];
		mem_we = 1'b0;
		if (state_r == ST_TABLE_READ)
		begin
			tlat_nxt = mem_rdata;
		end
		if (state_r != ST_IDLE)
		begin
			cnt_nxt = cnt_r - 4'd1;
			if (cnt_r == 4'd1)
			begin
				state_nxt = ST_IDLE;
			end
			else
			begin
				state_nxt = ST_EXTRA;
			end
		end
		if (issue)
		begin
			first_nxt = iw;
			cyc_nxt = CYC_ONE;
			pc_nxt = pc_inc;
			stby_nxt = 1'b0;
			pend_nxt = 1'b0;
			if (pend_r && iw[15:12] == OP_SECOND)
			begin
				// Second word consumed by its first word; together two cycles.
				cyc_nxt = CYC_TWO;
				if (first_r[11:8] == SUB_JUMP)
				begin
					pc_nxt = {iw[11:0], first_r[7:0], 1'b0};
				end
				else
				begin
					fsr_we = first_r[5:4] != 2'b11;
					fsr_sel = first_r[5:4];
					fsr_val = {first_r[3:0], iw[7:0]};
				end
			end
			else if (iw[15:12] == OP_SECOND || iw == 16'h0000)
			begin
				cyc_nxt = CYC_ONE;
			end
			else if (iw[15:12] == OP_CTRL)
			begin
				if (iw[11] == 1'b0 && cond_true)
				begin
					pc_nxt = pc_inc + {{12{k[7]}}, k, 1'b0};
					cyc_nxt = CYC_TWO;
					state_nxt = ST_EXTRA;
					cnt_nxt = 4'd1;
				end
				else if (iw[11:8] == SUB_JUMP)
				begin
					pend_nxt = 1'b1;
				end
				else if (iw[11:8] == SUB_PTRLD && iw[7:6] == 2'b00)
				begin
					pend_nxt = 1'b1;
				end
			end
			else if (iw[15:12] == OP_LIT)
			begin
				case (iw[11:8])
					LIT_ADD:
					begin
						w_nxt = add_sum[7:0];
						flg_nxt = '{n: add_sum[7], ov: (w_r[7] == k[7]) && (add_sum[7] != w_r[7]),
							z: add_sum[7:0] == 8'h00, dc: add_lo[4], c: add_sum[8]};
					end
					LIT_SUB:
					begin
						w_nxt = sub_sum[7:0];
						flg_nxt = '{n: sub_sum[7], ov: (k[7] != w_r[7]) && (sub_sum[7] != k[7]),
							z: sub_sum[7:0] == 8'h00, dc: sub_lo[4], c: sub_sum[8]};
					end
					LIT_AND, LIT_OR, LIT_XOR:
					begin
						w_nxt = logic_res;
						flg_nxt.z = logic_res == 8'h00;
						flg_nxt.n = logic_res[7];
					end
					LIT_MOVE: w_nxt = k;
					LIT_MUL: prod_nxt = {8'h00, w_r} * {8'h00, k};
					LIT_RET:
					begin
						w_nxt = k;
						pc_nxt = top_r;
						sp_nxt = sp_r - 5'd1;
						cyc_nxt = CYC_TWO;
						state_nxt = ST_EXTRA;
						cnt_nxt = 4'd1;
					end
					LIT_BANK:
					begin
						if (iw[7:4] == 4'h0)
						begin
							bank_nxt = iw[3:0];
						end
					end
					4'h0:
					begin
						if (k == MISC_PUSH)
						begin
							top_nxt = pc_inc;
							sp_nxt = sp_r + 5'd1;
						end
						else if (k == MISC_POP)
						begin
							sp_nxt = sp_r - 5'd1;
						end
						else if (k[7:1] == MISC_IRET)
						begin
							pc_nxt = top_r;
							sp_nxt = sp_r - 5'd1;
							irqh_nxt = 1'b1;
							irql_nxt = 1'b1;
							cyc_nxt = CYC_TWO;
							state_nxt = ST_EXTRA;
							cnt_nxt = 4'd1;
						end
						else if (k == MISC_STANDBY)
						begin
							to_nxt = 1'b1;
							pdn_nxt = 1'b0;
							stby_nxt = 1'b1;
						end
						else if (k[7:2] == MISC_TABLE)
						begin
							cyc_nxt = CYC_TWO;
							state_nxt = ST_TABLE_READ;
							cnt_nxt = 4'd1;
						end
						else if (k[7:2] == (MISC_TABLE | 6'h01))
						begin
							mem_we = ctrl_r[CTRL_TBLWR_EN];
							cyc_nxt = ctrl_r[CTRL_TBLWR_EN] ? CYC_TBLWR : CYC_TWO;
							state_nxt = ST_EXTRA;
							cnt_nxt = cyc_nxt - 4'd1;
						end
						if (k[7:3] == 5'b00001)
						begin
							case (k[1:0])
								TP_NONE: tptr_nxt = tptr_r;
								TP_POSTINC: tptr_nxt = tptr_r + 16'h0001;
								TP_POSTDEC: tptr_nxt = tptr_r - 16'h0001;
								TP_PREINC: tptr_nxt = tp_use;
								default: tptr_nxt = tptr_r;
							endcase
						end
					end
					default: cyc_nxt = CYC_ONE;
				endcase
			end
		end
	end

	// Timer prescaler: tick once per 2^(sel+1) clocks when assigned, else every clock.
	assign psc_mask = 8'((9'h002 << ctrl_r[CTRL_PSC_SEL +: 3]) - 9'h001);
	assign tmr_tick = !ctrl_r[CTRL_PSC_ASSIGN] || &(psc_r | ~psc_mask);

	cltd_table_mem u_mem
	(
		.hclk(hclk),
		.we(mem_we),
		.addr(mem_addr),
		.wdata(tlat_r),
		.rdata(mem_rdata)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_fsr
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
					fsr_r[gi] <= 12'h000;
				else if (fsr_we && fsr_sel == 2'(gi))
					fsr_r[gi] <= fsr_val;
			end
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			aph_r <= '0;
			dph_r <= 1'b0;
		end
		else if (hready)
		begin
			aph_r <= '{wr: hwrite, addr: haddr[7:0]};
			dph_r <= aph_valid;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_r <= ST_IDLE;
			{cnt_r, cyc_r, flg_r, w_r, pc_r, top_r, sp_r, bank_r} <= '0;
			{tptr_r, tlat_r, prod_r, first_r} <= '0;
			{to_r, pdn_r} <= 2'b11;
			{irqh_r, irql_r, stby_r, pend_r} <= 4'h0;
		end
		else
		begin
			state_r <= state_nxt;
			{cnt_r, cyc_r, flg_r, w_r, pc_r, top_r, sp_r, bank_r} <=
				{cnt_nxt, cyc_nxt, flg_nxt, w_nxt, pc_nxt, top_nxt, sp_nxt, bank_nxt};
			{tptr_r, tlat_r, prod_r, first_r} <= {tptr_nxt, tlat_nxt, prod_nxt, first_nxt};
			{to_r, pdn_r} <= {to_nxt, pdn_nxt};
			{irqh_r, irql_r, stby_r, pend_r} <= {irqh_nxt, irql_nxt, stby_nxt, pend_nxt};
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_r <= CTRL_RESET;
			{tmr_r, psc_r, latch_r} <= '0;
		end
		else
		begin
			ctrl_r <= sel_ctrl ? hwdata[4:0] : ctrl_r;
			latch_r <= sel_port ? hwdata[7:0] : latch_r;
			if (sel_tmr)
			begin
				tmr_r <= hwdata[7:0];
				psc_r <= ctrl_r[CTRL_PSC_ASSIGN] ? 8'h00 : psc_r + 8'h01;
			end
			else
			begin
				tmr_r <= tmr_tick ? tmr_r + 8'h01 : tmr_r;
				psc_r <= psc_r + 8'h01;
			end
		end
	end

endmodule : cltd_decoder
`default_nettype wire

// ### sim/cltd_decoder_sva.sv
/*
 * Checker of the decoder's bus answers, port pins and standby output.
 * Assumes it is bound to cltd_decoder and sees only that module's ports.
 */
`timescale 1ns/100ps
`default_nettype none
module cltd_decoder_sva
	import cltd_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	input wire logic [7:0] port_pins,
	input wire logic [7:0] port_latch,
	input wire logic standby
);
	logic wr_ph_r;
	logic rd_ph_r;
	logic [7:0] addr_r;
	wire logic aph;
	wire logic port_wr;
	wire logic sb_issue;
	assign aph = hsel && htrans[1] && hready;
	assign port_wr = wr_ph_r && addr_r == ADDR_PORT;
	assign sb_issue = wr_ph_r && addr_r == ADDR_INSTR && hwdata[15:0] == 16'h0003;

	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			{wr_ph_r, rd_ph_r, addr_r} <= '0;
		else
			{wr_ph_r, rd_ph_r, addr_r} <= {aph && hwrite, aph && !hwrite, haddr[7:0]};

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_ready; hreadyout && !hresp; endproperty
	a_ready: assert property (p_ready) else $error("bus answer not ready or not okay");
	property p_idle_zero; !rd_ph_r |-> hrdata == 32'h0; endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("read data outside a read");
	property p_pins; rd_ph_r && addr_r == ADDR_PORT |-> hrdata == {24'h0, port_pins}; endproperty
	a_pins: assert property (p_pins) else $error("port read not from pins");
	property p_latch_load; port_wr |=> port_latch == $past(hwdata[7:0]); endproperty
	a_latch_load: assert property (p_latch_load) else $error("port latch not loaded");
	property p_latch_hold; !port_wr |=> $stable(port_latch); endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("port latch changed alone");
	property p_sb_rise; $rose(standby) |-> $past(sb_issue); endproperty
	a_sb_rise: assert property (p_sb_rise) else $error("standby without its word");
	property p_sb_clear;
		standby && wr_ph_r && addr_r == ADDR_INSTR && hwdata[15:0] != 16'h0003 |=> !standby;
	endproperty
	a_sb_clear: assert property (p_sb_clear) else $error("standby kept after new word");
	property p_sb_stat;
		rd_ph_r && addr_r == ADDR_STATUS && standby |-> hrdata[6:5] == 2'b01 && hrdata[STAT_STANDBY];
	endproperty
	a_sb_stat: assert property (p_sb_stat) else $error("standby status bits wrong");

	c_pins: cover property (rd_ph_r && addr_r == ADDR_PORT);
	c_sb: cover property ($rose(standby));
	c_issue: cover property (wr_ph_r && addr_r == ADDR_INSTR);
endmodule : cltd_decoder_sva

bind cltd_decoder cltd_decoder_sva cltd_decoder_sva_inst (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
	.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
	.port_pins(port_pins), .port_latch(port_latch), .standby(standby));
`default_nettype wire

// ### sim/cltd_decoder_tb_top.sv
/*
 * Self-checking bench of the decoder: issues words over AHB-Lite and reads state back.
 * Assumes the decoder answers with zero wait states on a single-slave bus.
 */
`timescale 1ns/100ps
`default_nettype none
module cltd_decoder_tb_top;
	import cltd_pkg::*;
	logic hclk;
	logic hresetn;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic [7:0] port_pins;
	logic hreadyout;
	logic [31:0] hrdata;
	logic hresp;
	logic [7:0] port_latch;
	logic standby;
	int fails;
	int checks;
	logic [31:0] rd;
	logic [31:0] snap;
	logic [20:0] pc;
	localparam logic [7:0] TAKEN = 8'h6A;
	// Word, expected working register, expected flags {n, ov, z, dc, c}.
	localparam logic [28:0] LIT [11] = '{{16'h0E7F, 8'h7F, 5'h00}, {16'h0F01, 8'h80, 5'h1A},
		{16'h0E00, 8'h00, 5'h1A}, {16'h0B0F, 8'h00, 5'h0E}, {16'h0980, 8'h80, 5'h1A},
		{16'h0AFF, 8'h7F, 5'h0A}, {16'h0801, 8'h82, 5'h10}, {16'h0D03, 8'h82, 5'h10},
		{16'h0105, 8'h82, 5'h10}, {16'h0000, 8'h82, 5'h10}, {16'hF123, 8'h82, 5'h10}};

	cltd_decoder cltd_decoder_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .port_pins(port_pins),
		.port_latch(port_latch), .standby(standby));

	task automatic close_out;
		$display("mismatches %0d, comparisons %0d", fails, checks);
		if (fails == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value at %0t: seen %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	// Read data are captured mid-cycle so the edge's own updates cannot race them.
	task automatic wait_ready;
		for (int i = 0; i < 16; i++)
		begin
			@(negedge hclk);
			snap = hrdata;
			@(posedge hclk);
			if (hreadyout === 1'b1)
				return;
		end
		fails++;
		close_out();
	endtask : wait_ready

	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= wr;
		wait_ready();
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
		rd = snap;
	endtask : xfer

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rchk

	task automatic wait_idle;
		for (int i = 0; i < 16; i++)
		begin
			xfer(1'b0, ADDR_STATUS, 32'h0);
			if (rd[STAT_BUSY] === 1'b0)
				return;
		end
		fails++;
		close_out();
	endtask : wait_idle

	task automatic issue(input logic [15:0] word);
		xfer(1'b1, ADDR_INSTR, {16'h0, word});
		wait_idle();
	endtask : issue

	initial
	begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	initial
	begin
		{hresetn, hsel, haddr, htrans, hwrite, hwdata, fails, checks} = '0;
		hsel = 1'b1;
		hsize = 3'b010;
		port_pins = 8'h3C;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rchk(ADDR_STATUS, 32'h60);
		xfer(1'b1, 8'hFC, 32'hFFFFFFFF);
		rchk(8'hFC, 32'h0);
		foreach (LIT[i])
		begin
			issue(LIT[i][28:13]);
			chk(32'(rd[4:0]), 32'(LIT[i][4:0]));
			chk(32'(rd[15:12]), 32'h1);
			rchk(ADDR_WORK, 32'(LIT[i][12:5]));
		end
		rchk(ADDR_PROD, 32'h186);
		rchk(ADDR_BANK, 32'h5);
		pc = 21'h16;
		for (int cc = 0; cc < 8; cc++)
		begin
			issue({OP_CTRL, 4'(cc), 8'hFE});
			chk(32'(rd[15:12]), TAKEN[cc] ? 32'h2 : 32'h1);
			chk(32'(rd[4:0]), 32'h10);
			pc = pc + 21'h2 - (TAKEN[cc] ? 21'h4 : 21'h0);
			rchk(ADDR_PC, 32'(pc));
		end
		issue(16'h0005);
		pc = pc + 21'h2;
		chk(32'(rd[20:12]), 32'h11);
		rchk(ADDR_STKTOP, 32'(pc));
		issue(16'hEF34);
		chk(32'(rd[STAT_PEND]), 32'h1);
		issue(16'hF012);
		chk(32'(rd[15:12]), 32'h2);
		rchk(ADDR_PC, 32'h2468);
		issue(16'h0C99);
		chk(32'(rd[20:12]), 32'h2);
		rchk(ADDR_PC, 32'(pc));
		rchk(ADDR_WORK, 32'h99);
		issue(16'h0005);
		issue(16'h0006);
		chk(32'(rd[20:12]), 32'h1);
		issue(16'h0005);
		issue(16'h0011);
		pc = pc + 21'h6;
		chk(32'(rd[15:12]), 32'h2);
		chk(32'(rd[8:7]), 32'h3);
		rchk(ADDR_PC, 32'(pc));
		issue(16'hEE0A);
		issue(16'hF0BC);
		chk(32'(rd[15:12]), 32'h2);
		rchk(ADDR_FSR0, 32'hABC);
		issue(16'hEE2A);
		issue(16'h0E11);
		issue(16'hF055);
		rchk(ADDR_FSR2, 32'h0);
		xfer(1'b1, ADDR_TBLPTR, 32'h3);
		xfer(1'b1, ADDR_TABLAT, 32'h5A);
		xfer(1'b1, ADDR_CTRL, 32'h1);
		xfer(1'b1, ADDR_INSTR, 32'h000C);
		xfer(1'b1, ADDR_INSTR, 32'h0E77);
		wait_idle();
		chk(32'(rd[15:12]), 32'h5);
		rchk(ADDR_WORK, 32'h11);
		for (int m = 1; m < 4; m++)
		begin
			issue(16'h000C | 16'(m));
			chk(32'(rd[15:12]), 32'h5);
			rchk(ADDR_TBLPTR, (m == 2) ? 32'h3 : 32'h4);
		end
		xfer(1'b1, ADDR_CTRL, 32'h0);
		issue(16'h000C);
		chk(32'(rd[15:12]), 32'h2);
		xfer(1'b1, ADDR_TBLPTR, 32'h3);
		for (int m = 0; m < 4; m++)
		begin
			xfer(1'b1, ADDR_TABLAT, 32'h0);
			issue(16'h0008 | 16'(m));
			chk(32'(rd[15:12]), 32'h2);
			rchk(ADDR_TABLAT, 32'h5A);
			rchk(ADDR_TBLPTR, m[0] ? 32'h4 : 32'h3);
		end
		xfer(1'b1, ADDR_PORT, 32'hA5);
		@(negedge hclk);
		chk(32'(port_latch), 32'hA5);
		@(posedge hclk);
		rchk(ADDR_PORT, 32'h3C);
		port_pins <= 8'hC3;
		rchk(ADDR_PORT, 32'hC3);
		xfer(1'b1, ADDR_CTRL, 32'h1E);
		repeat (200) @(posedge hclk);
		xfer(1'b1, ADDR_TIMER, 32'h10);
		repeat (240) @(posedge hclk);
		rchk(ADDR_TIMER, 32'h10);
		// The first tick lands 256 clocks after the load only if the load cleared the prescaler.
		repeat (20) @(posedge hclk);
		rchk(ADDR_TIMER, 32'h11);
		issue(16'h0003);
		chk(32'(rd[15:5]), 32'hCD);
		chk(32'(standby), 32'h1);
		issue(16'h0000);
		chk(32'(standby), 32'h0);
		close_out();
	end
endmodule : cltd_decoder_tb_top
`default_nettype wire
